/* bus_pkg.sv */
// Package with the constants and carrier types of the external bus interface.
package bus_pkg;

    // ****************************************
    // Address map
    // ****************************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [7:0]  BANK_ZERO   = 8'h00;
    localparam logic [15:0] PERIPH_LAST = 16'h007f;
    localparam logic [15:0] RAM_FIRST   = 16'h0080;
    localparam logic [15:0] RAM_LAST    = 16'h047f;
    localparam logic [15:0] VEC_FIRST   = 16'hffdc;
    localparam logic [15:0] DP_SIZE     = 16'h0100;
    localparam int RAM_WORDS  = 512;
    localparam int RAM_AW     = 9;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_DIV = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        REGION_PERIPH,
        REGION_RAM,
        REGION_EXT
    } region_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              write;
        logic              word;
        logic              dp_rel;
    } bus_req_t;

    typedef struct packed {
        logic              strobe_n;
        logic              rd_wr;
        logic              odd_byte_enable_n;
        logic              addr_latch;
        logic [7:0]        addr_low;
    } bus_ctl_t;

    // Region decode of a full 24-bit address.
    function automatic region_t decode_region(input logic [ADDR_W-1:0] a);
        region_t r;
        r = REGION_EXT;
        if (a[23:16] == BANK_ZERO) begin
            if (a[15:0] <= PERIPH_LAST) begin
                r = REGION_PERIPH;
            end else if (a[15:0] <= RAM_LAST) begin
                r = REGION_RAM;
            end
        end
        return r;
    endfunction

endpackage

/* clk_halver.sv */
// Divide-by-two output clock generator.
`timescale 1ns/1ps
`default_nettype none
module clk_halver (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Divided clock
    output logic      phase_o
);
    logic phase_q;
    logic phase_d;

    always_comb begin
        phase_d = ~phase_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;
endmodule
`default_nettype wire

/* ram_mem.sv */
// Internal RAM storage with registered read data and byte writes.
`timescale 1ns/1ps
`default_nettype none
module ram_mem (
    // Clock
    input  wire logic                   clk_i,
    // Access
    input  wire logic                   en_i,
    input  wire logic                   we_i,
    input  wire logic [1:0]             be_i,
    input  wire logic [bus_pkg::RAM_AW-1:0] addr_i,
    input  wire logic [15:0]            wdata_i,
    // Read data
    output logic      [15:0]            rdata_o
);
    logic [15:0] mem [bus_pkg::RAM_WORDS];
    logic [15:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (en_i && we_i && be_i[0]) begin
            mem[addr_i][7:0] <= wdata_i[7:0];
        end
        if (en_i && we_i && be_i[1]) begin
            mem[addr_i][15:8] <= wdata_i[15:8];
        end
        if (en_i) begin
            rdata_q <= mem[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule
`default_nettype wire

/* ext_bus.sv */
// External bus interface and bank-0 address decoder of the microcomputer.
`timescale 1ns/1ps
`default_nettype none
module ext_bus (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Core request and answer
    input  wire logic               req_valid_i,
    input  wire bus_pkg::bus_req_t  req_i,
    input  wire logic [15:0]        direct_page_base_i,
    output logic                    req_ready_o,
    output logic                    rsp_valid_o,
    output logic [15:0]             rsp_rdata_o,
    output logic                    vector_fetch_o,
    // Peripheral register port
    output logic                    periph_sel_o,
    output logic [6:0]              periph_addr_o,
    input  wire logic [15:0]        periph_rdata_i,
    // Straps and handshake pins
    input  wire logic               byte_mode_i,
    input  wire logic               ready_n_i,
    input  wire logic               hold_req_n_i,
    output logic                    bus_hold_grant_n_o,
    output logic                    core_run_o,
    output logic                    phi_clk_o,
    // External bus pins
    output bus_pkg::bus_ctl_t       ctl_o,
    output logic                    ctl_oe_o,
    output logic [7:0]              mid_o,
    output logic                    mid_oe_o,
    input  wire logic [7:0]         mid_i,
    output logic [7:0]              upper_o,
    output logic                    upper_oe_o,
    input  wire logic [7:0]         upper_i
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_INT,
        ST_HOLD
    } state_t;

    state_t                      state_q, state_d;
    bus_pkg::bus_req_t           cur_q, cur_d;
    logic                        second_q, second_d;
    logic [15:0]                 rdata_q, rdata_d;
    logic                        rsp_q, rsp_d;
    bus_pkg::region_t            reg_q, reg_d;
    logic                        grant_n_q, grant_n_d;
    bus_pkg::bus_ctl_t           ctl_q, ctl_d;
    logic                        oe_q, oe_d;
    logic [7:0]                  mid_q, mid_d;
    logic                        mid_oe_q, mid_oe_d;
    logic [7:0]                  upper_q, upper_d;
    logic                        upper_oe_q, upper_oe_d;

    logic [bus_pkg::ADDR_W-1:0]  eff_addr;
    bus_pkg::region_t            eff_region;
    logic                        run;
    logic                        ram_en;
    logic [15:0]                 ram_rdata;
    logic [1:0]                  ram_be;

    // ****************************************
    // Address formation and decode
    // ****************************************
    // Direct page offsets do not wrap within bank 0; carry into bank 1 is kept
    // because a base near the top of bank 0 spans the boundary.
    always_comb begin
        eff_addr = req_i.addr;
        if (req_i.dp_rel) begin
            eff_addr = {8'h00, 16'h0000} + 24'(direct_page_base_i)
                       + 24'(req_i.addr[7:0]);
        end
        eff_region = bus_pkg::decode_region(eff_addr);
    end

    assign run            = ready_n_i;
    assign core_run_o     = run;
    assign req_ready_o    = (state_q == ST_IDLE) && hold_req_n_i && run;
    assign vector_fetch_o = (eff_addr[23:16] == bus_pkg::BANK_ZERO)
                            && (eff_addr[15:0] >= bus_pkg::VEC_FIRST)
                            && !req_i.write;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d    = state_q;
        cur_d      = cur_q;
        second_d   = second_q;
        rdata_d    = rdata_q;
        rsp_d      = 1'b0;
        reg_d      = reg_q;
        grant_n_d  = grant_n_q;
        ctl_d      = ctl_q;
        oe_d       = oe_q;
        mid_d      = mid_q;
        mid_oe_d   = mid_oe_q;
        upper_d    = upper_q;
        upper_oe_d = upper_oe_q;
        ctl_d.addr_latch = 1'b0;
        if (run) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (!hold_req_n_i) begin
                        state_d    = ST_HOLD;
                        grant_n_d  = 1'b0;
                        oe_d       = 1'b0;
                        mid_oe_d   = 1'b0;
                        upper_oe_d = 1'b0;
                    end else if (req_valid_i) begin
                        cur_d      = req_i;
                        cur_d.addr = eff_addr;
                        reg_d      = eff_region;
                        second_d   = 1'b0;
                        if (eff_region == bus_pkg::REGION_EXT) begin
                            state_d = ST_ADDR;
                            oe_d    = 1'b1;
                            ctl_d.addr_low = eff_addr[7:0];
                            ctl_d.addr_latch = 1'b1;
                            ctl_d.rd_wr = !req_i.write;
                            // A wide word at an even address also moves its odd byte.
                            ctl_d.odd_byte_enable_n = !(eff_addr[0]
                                                        || (req_i.word && !byte_mode_i));
                            mid_d      = eff_addr[15:8];
                            mid_oe_d   = 1'b1;
                            upper_d    = eff_addr[23:16];
                            upper_oe_d = 1'b1;
                        end else begin
                            state_d = ST_INT;
                        end
                    end
                end
                ST_ADDR: begin
                    state_d = ST_STROBE;
                    ctl_d.strobe_n = 1'b0;
                    if (!byte_mode_i && !cur_q.addr[0]) begin
                        mid_d    = cur_q.wdata[15:8];
                        mid_oe_d = cur_q.write;
                    end
                    upper_d    = (cur_q.addr[0] && !byte_mode_i) ? cur_q.wdata[15:8]
                                 : (second_q ? cur_q.wdata[15:8] : cur_q.wdata[7:0]);
                    upper_oe_d = cur_q.write;
                end
                ST_STROBE: begin
                    ctl_d.strobe_n = 1'b1;
                    mid_d      = cur_q.addr[15:8];
                    mid_oe_d   = 1'b1;
                    upper_d    = cur_q.addr[23:16];
                    upper_oe_d = 1'b1;
                    if (!second_q) begin
                        rdata_d[7:0] = upper_i;
                        if (!byte_mode_i) begin
                            rdata_d[15:8] = cur_q.addr[0] ? 8'h00 : mid_i;
                            if (cur_q.addr[0]) begin
                                rdata_d[7:0] = mid_i;
                            end
                        end
                    end else begin
                        rdata_d[15:8] = upper_i;
                    end
                    // An 8-bit bus moves a word as two byte cycles, low byte first.
                    if (cur_q.word && byte_mode_i && !second_q) begin
                        second_d   = 1'b1;
                        cur_d.addr = cur_q.addr + 24'h000001;
                        state_d    = ST_ADDR;
                        ctl_d.addr_low = cur_q.addr[7:0] + 8'h01;
                        ctl_d.addr_latch = 1'b1;
                        ctl_d.odd_byte_enable_n = cur_q.addr[0];
                        mid_d   = cur_d.addr[15:8];
                        upper_d = cur_d.addr[23:16];
                    end else begin
                        state_d = ST_IDLE;
                        rsp_d   = 1'b1;
                    end
                end
                ST_INT: begin
                    rdata_d = (reg_q == bus_pkg::REGION_RAM) ? ram_rdata : periph_rdata_i;
                    rsp_d   = 1'b1;
                    state_d = ST_IDLE;
                end
                ST_HOLD: begin
                    if (hold_req_n_i) begin
                        state_d   = ST_IDLE;
                        grant_n_d = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= ST_IDLE;
            cur_q      <= '0;
            second_q   <= 1'b0;
            rdata_q    <= 16'h0000;
            rsp_q      <= 1'b0;
            reg_q      <= bus_pkg::REGION_EXT;
            grant_n_q  <= 1'b1;
            ctl_q      <= '{strobe_n: 1'b1, rd_wr: 1'b1, odd_byte_enable_n: 1'b1,
                            addr_latch: 1'b0, addr_low: 8'h00};
            oe_q       <= 1'b1;
            mid_q      <= 8'h00;
            mid_oe_q   <= 1'b0;
            upper_q    <= 8'h00;
            upper_oe_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cur_q      <= cur_d;
            second_q   <= second_d;
            rdata_q    <= rdata_d;
            rsp_q      <= rsp_d;
            reg_q      <= reg_d;
            grant_n_q  <= grant_n_d;
            ctl_q      <= ctl_d;
            oe_q       <= oe_d;
            mid_q      <= mid_d;
            mid_oe_q   <= mid_oe_d;
            upper_q    <= upper_d;
            upper_oe_q <= upper_oe_d;
        end
    end

    // ****************************************
    // Internal memories
    // ****************************************
    always_comb begin
        ram_en = run && (state_q == ST_IDLE) && req_valid_i && hold_req_n_i
                 && (eff_region == bus_pkg::REGION_RAM);
        ram_be = req_i.word ? 2'b11 : (eff_addr[0] ? 2'b10 : 2'b01);
    end

    localparam int RAM_IDX_W = bus_pkg::RAM_AW;

    ram_mem u_ram (
        .clk_i   (clk_i),
        .en_i    (ram_en),
        .we_i    (req_i.write),
        .be_i    (ram_be),
        .addr_i  (RAM_IDX_W'((eff_addr[15:0] - bus_pkg::RAM_FIRST) >> 1)),
        .wdata_i (req_i.wdata),
        .rdata_o (ram_rdata)
    );

    assign periph_sel_o  = (state_q == ST_INT) && (reg_q == bus_pkg::REGION_PERIPH);
    assign periph_addr_o = cur_q.addr[6:0];

    clk_halver u_phi (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .phase_o (phi_clk_o)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign rsp_valid_o        = rsp_q;
    assign rsp_rdata_o        = rdata_q;
    assign bus_hold_grant_n_o = grant_n_q;
    assign ctl_o              = ctl_q;
    assign ctl_oe_o           = oe_q;
    assign mid_o              = mid_q;
    assign mid_oe_o           = mid_oe_q;
    assign upper_o            = upper_q;
    assign upper_oe_o         = upper_oe_q;
endmodule
`default_nettype wire

/* ext_bus_asserts.sv */
// Concurrent checks on the pins of the external bus interface.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker (
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    // Core side and straps
    input wire logic              req_valid_i,
    input wire bus_pkg::bus_req_t req_i,
    input wire logic              req_ready_o,
    input wire logic              byte_mode_i,
    input wire logic              ready_n_i,
    input wire logic              hold_req_n_i,
    input wire logic              bus_hold_grant_n_o,
    input wire logic              phi_clk_o,
    // Bus pins
    input wire bus_pkg::bus_ctl_t ctl_o,
    input wire logic              ctl_oe_o,
    input wire logic [7:0]        mid_o,
    input wire logic              mid_oe_o,
    input wire logic              upper_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take_abs;
    logic take_int;
    logic take_ext;
    assign take_abs = req_valid_i && req_ready_o && !req_i.dp_rel;
    assign take_int = take_abs && req_i.addr[23:16] == 8'h00 && req_i.addr[15:0] <= 16'h047f;
    assign take_ext = take_abs && req_i.addr[23:16] != 8'h00;
    // ****************************************
    // Pin checks
    // ****************************************
    property p_strobe_owned; !ctl_o.strobe_n |-> ctl_oe_o && bus_hold_grant_n_o; endproperty
    a_strobe_owned: assert property (p_strobe_owned) else $error("strobe low off the bus");
    property p_phi_half; $past(rst_n_i) |-> phi_clk_o != $past(phi_clk_o); endproperty
    a_phi_half: assert property (p_phi_half) else $error("output clock missed a toggle");
    property p_stall; !ready_n_i |-> !req_ready_o ##1 $stable(ctl_o); endproperty
    a_stall: assert property (p_stall) else $error("bus moved while not ready");
    property p_hold_float; !bus_hold_grant_n_o |-> !ctl_oe_o && !mid_oe_o && !upper_oe_o; endproperty
    a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");
    property p_hold_grant; (!hold_req_n_i && ready_n_i) [*8] |-> !bus_hold_grant_n_o; endproperty
    a_hold_grant: assert property (p_hold_grant) else $error("hold not granted");
    property p_rw_dir; !ctl_o.strobe_n |-> ctl_o.rd_wr == !upper_oe_o; endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction disagrees with data drive");
    property p_odd; ctl_o.addr_latch && ctl_o.addr_low[0] |-> !ctl_o.odd_byte_enable_n; endproperty
    a_odd: assert property (p_odd) else $error("odd address without byte enable");
    property p_mid16; !byte_mode_i && !ctl_o.strobe_n && ctl_o.rd_wr |-> !mid_oe_o; endproperty
    a_mid16: assert property (p_mid16) else $error("middle lines driven in wide read");
    property p_mid8; byte_mode_i && $fell(ctl_o.strobe_n) |-> mid_oe_o && $stable(mid_o); endproperty
    a_mid8: assert property (p_mid8) else $error("middle lines left address");
    property p_latch; ctl_o.addr_latch |-> ctl_o.strobe_n && upper_oe_o && mid_oe_o; endproperty
    a_latch: assert property (p_latch) else $error("address not out at latch");
    property p_ext; take_ext |-> ##[1:2] ctl_o.addr_latch; endproperty
    a_ext: assert property (p_ext) else $error("outer bank not sent to bus");
    property p_int; take_int |=> !ctl_o.addr_latch [*3]; endproperty
    a_int: assert property (p_int) else $error("internal access reached bus");
endmodule
`default_nettype wire

/* ext_mem_model.sv */
// Behavioural external memory on the multiplexed bus, with a settable wait.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Wire levels seen on the bus
    input  wire bus_pkg::bus_ctl_t ctl_i,
    input  wire logic [7:0]        mid_i,
    input  wire logic [7:0]        upper_i,
    input  wire logic              byte_mode_i,
    input  wire logic [1:0]        stall_i,
    // Answers
    output logic      [7:0]        mid_o,
    output logic      [7:0]        upper_o,
    output logic                   ready_n_o
);
    // ****************************************
    // Memory
    // ****************************************
    logic [7:0]  mem [0:255];
    logic [23:0] addr_q;
    logic [1:0]  wait_q;
    logic [7:0]  last_mid_q;
    logic [7:0]  last_up_q;
    logic        rd_drive;
    logic        rom_hit;
    assign rd_drive = !ctl_i.strobe_n && ctl_i.rd_wr;
    assign rom_hit = addr_q >= 24'h00ffdc && addr_q <= 24'h00ffff;
    assign ready_n_o = ctl_i.strobe_n || wait_q == 2'h0;
    // Released lines show the inverse of the last level, so a stale copy never passes.
    assign upper_o = rd_drive ? mem[byte_mode_i ? addr_q[7:0] : {addr_q[7:1], 1'h0}] : ~last_up_q;
    assign mid_o = (rd_drive && !byte_mode_i) ? mem[{addr_q[7:1], 1'h1}] : ~last_mid_q;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        last_up_q <= upper_o;
        last_mid_q <= mid_o;
        if (!rst_n_i) begin
            wait_q <= 2'h0;
        end else if (ctl_i.addr_latch) begin
            addr_q <= {upper_i, mid_i, ctl_i.addr_low};
            wait_q <= stall_i;
        end else if (!ctl_i.strobe_n && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end
        if (rst_n_i && !ctl_i.strobe_n && !ctl_i.rd_wr && !rom_hit) begin
            if (byte_mode_i) mem[addr_q[7:0]] <= upper_i;
            else if (!addr_q[0]) mem[addr_q[7:0]] <= upper_i;
            if (!byte_mode_i && !ctl_i.odd_byte_enable_n) mem[{addr_q[7:1], 1'h1}] <= mid_i;
        end
    end
endmodule
`default_nettype wire

/* test_external_bus_and_memory_map.sv */
// Self-checking bench for the external bus interface and its address decode.
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_and_memory_map;
    typedef struct {
        logic [23:0] addr; logic [15:0] wdata; logic write; logic bm; logic dp;
        logic [15:0] dpb; logic [15:0] exp;
    } row_t;
    logic clk_i, rst_n_i, req_valid_i, byte_mode_i, ready_n_i, hold_req_n_i;
    logic req_ready_o, rsp_valid_o, vector_fetch_o, bus_hold_grant_n_o, phi_clk_o;
    logic ctl_oe_o, mid_oe_o, upper_oe_o;
    logic [15:0] direct_page_base_i, rsp_rdata_o;
    logic [15:0] periph_rdata_i;
    logic periph_sel_o;
    logic [6:0] periph_addr_o;
    logic [7:0] mid_o, upper_o, mid_w, upper_w, mem_mid, mem_up;
    logic [1:0] stall_q;
    bus_pkg::bus_req_t req_i;
    bus_pkg::bus_ctl_t ctl_o;
    int n_fail = 0;
    int n_compared = 0;
    row_t rows [14] = '{
        '{24'h012340, 16'hbeef, 1'h1, 1'h0, 1'h0, 16'h0000, 16'h0000},
        '{24'h012340, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'hbeef},
        '{24'h020350, 16'h1234, 1'h1, 1'h1, 1'h0, 16'h0000, 16'h0000},
        '{24'h020350, 16'h0000, 1'h0, 1'h1, 1'h0, 16'h0000, 16'h1234},
        '{24'h000080, 16'ha5c3, 1'h1, 1'h0, 1'h0, 16'h0000, 16'h0000},
        '{24'h00047e, 16'h3c5a, 1'h1, 1'h0, 1'h0, 16'h0000, 16'h0000},
        '{24'h000080, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'ha5c3},
        '{24'h00047e, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h3c5a},
        '{24'h000010, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h7e81},
        '{24'h00ffde, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h8584},
        '{24'h000020, 16'h0f0f, 1'h1, 1'h0, 1'h1, 16'h0100, 16'h0000},
        '{24'h000120, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h0f0f},
        '{24'h000090, 16'h6699, 1'h1, 1'h0, 1'h1, 16'hff80, 16'h0000},
        '{24'h010010, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0000, 16'h6699}
    };
    // Only a selected register at the right offset answers, so select and offset are checked.
    assign periph_rdata_i = (periph_sel_o && periph_addr_o == 7'h10) ? 16'h7e81 : 16'h0000;
    assign mid_w = mid_oe_o ? mid_o : mem_mid;
    assign upper_w = upper_oe_o ? upper_o : mem_up;
    ext_bus ext_bus_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .direct_page_base_i(direct_page_base_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .vector_fetch_o(vector_fetch_o),
        .periph_sel_o(periph_sel_o), .periph_addr_o(periph_addr_o),
        .periph_rdata_i(periph_rdata_i),
        .byte_mode_i(byte_mode_i), .ready_n_i(ready_n_i), .hold_req_n_i(hold_req_n_i),
        .bus_hold_grant_n_o(bus_hold_grant_n_o), .core_run_o(), .phi_clk_o(phi_clk_o),
        .ctl_o(ctl_o), .ctl_oe_o(ctl_oe_o), .mid_o(mid_o), .mid_oe_o(mid_oe_o), .mid_i(mid_w),
        .upper_o(upper_o), .upper_oe_o(upper_oe_o), .upper_i(upper_w));
    ext_mem_model ext_mem_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl_i(ctl_o),
        .mid_i(mid_w), .upper_i(upper_w), .byte_mode_i(byte_mode_i), .stall_i(stall_q),
        .mid_o(mem_mid), .upper_o(mem_up), .ready_n_o(ready_n_i));
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic reset_pulse;
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        check("idle pins", 16'({ctl_o.strobe_n, ctl_o.rd_wr, ctl_o.odd_byte_enable_n,
            ctl_o.addr_latch, bus_hold_grant_n_o, mid_oe_o, upper_oe_o, phi_clk_o}), 16'h00e8);
        rst_n_i <= 1'h1;
    endtask
    task automatic do_req(input row_t r, input logic [1:0] stall);
        int n;
        n = 0;
        @(posedge clk_i);
        req_i <= '{addr: r.addr, wdata: r.wdata, write: r.write, word: 1'h1, dp_rel: r.dp};
        direct_page_base_i <= r.dpb;
        byte_mode_i <= r.bm;
        stall_q <= stall;
        req_valid_i <= 1'h1;
        do begin @(negedge clk_i); n++; end while (req_ready_o !== 1'h1 && n < 40);
        check("vector flag", 16'(vector_fetch_o), 16'(!r.write && !r.dp &&
            r.addr >= 24'h00ffdc && r.addr <= 24'h00ffff));
        @(posedge clk_i);
        req_valid_i <= 1'h0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (rsp_valid_o !== 1'h1 && n < 40);
        check("answer", 16'(rsp_valid_o), 16'h0001);
        if (!r.write) check("read data", rsp_rdata_o, r.exp);
    endtask
    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        rst_n_i = 1'h0;
        req_valid_i = 1'h0;
        req_i = '0;
        byte_mode_i = 1'h0;
        hold_req_n_i = 1'h1;
        direct_page_base_i = 16'h0000;
        stall_q = 2'h0;
        reset_pulse();
        foreach (rows[i]) begin
            do_req(rows[i], 2'h0);
            $display("test %0d done", i);
        end
        do_req(rows[1], 2'h3);
        do_req(rows[3], 2'h2);
        $display("test stall done");
        @(posedge clk_i);
        hold_req_n_i <= 1'h0;
        fork
            do_req(rows[1], 2'h0);
            begin
                repeat (10) @(negedge clk_i);
                check("hold grant", 16'(bus_hold_grant_n_o), 16'h0000);
                check("ready in hold", 16'(req_ready_o), 16'h0000);
                @(posedge clk_i);
                hold_req_n_i <= 1'h1;
            end
        join
        $display("test hold done");
        reset_pulse();
        do_req(rows[13], 2'h1);
        $display("test second reset done");
        complete_run();
    end
    // The run should take well under a thousand cycles; this only cuts a hang short.
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        complete_run();
    end
endmodule
bind ext_bus ext_bus_checker ext_bus_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .byte_mode_i(byte_mode_i), .ready_n_i(ready_n_i), .hold_req_n_i(hold_req_n_i),
    .bus_hold_grant_n_o(bus_hold_grant_n_o), .phi_clk_o(phi_clk_o), .ctl_o(ctl_o),
    .ctl_oe_o(ctl_oe_o), .mid_o(mid_o), .mid_oe_o(mid_oe_o), .upper_oe_o(upper_oe_o));
`default_nettype wire
